// ==== logic/cmbi_pkg.sv ====
/*
  Shared constants and carrier types for the core memory bus interface:
  bus widths, peripheral window, access sizes and the request/command structs.
  Assumes one core clock and synchronous memories that answer one cycle after
  a read command is presented.
*/
package cmbi_pkg;

  localparam int PGM_AW = 21;
  localparam int PGM_DW = 16;
  localparam int DATA_AW = 24;
  localparam int DATA_DW = 32;
  localparam int SEC_DW = 16;
  localparam int PERI_DW = 16;
  localparam int PERI_AW = 16;

  // Peripheral window: upper address bits equal to this base select the register bus
  localparam logic [DATA_AW-1:0] PERI_BASE = 24'h00f000;
  localparam int PERI_WIN_BITS_DEF = 12;

  localparam int ADDR_MSB = DATA_AW - 1;

  typedef enum logic [1:0] {
    CMBI_SZ_BYTE = 2'b00,
    CMBI_SZ_WORD = 2'b01,
    CMBI_SZ_LONG = 2'b10
  } cmbi_size_t;

  typedef struct packed {
    logic pgmReq;
    logic pgmWrite;
    logic [PGM_AW-1:0] pgmAddr;
    logic dataReq;
    logic dataWrite;
    cmbi_size_t dataSize;
    logic [DATA_AW-1:0] primaryDataAddress;
    logic [DATA_DW-1:0] writeData;
    logic dualReq;
    logic [DATA_AW-1:0] secondaryDataAddress;
  } cmbi_core_req_t;

  typedef struct packed {
    logic pgmValid;
    logic [PGM_DW-1:0] pgmData;
    logic primValid;
    logic [DATA_DW-1:0] primData;
    logic secValid;
    logic [SEC_DW-1:0] secondaryReadBus;
  } cmbi_core_rsp_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [PGM_AW-1:0] addr;
    logic [PGM_DW-1:0] wdata;
  } cmbi_pmem_cmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    cmbi_size_t size;
    logic [DATA_AW-1:0] addr;
    logic [DATA_DW-1:0] wdata;
  } cmbi_xmem_cmd_t;

  typedef struct packed {
    logic rd;
    logic [DATA_AW-1:0] addr;
  } cmbi_smem_cmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [PERI_AW-1:0] addr;
    logic [PERI_DW-1:0] wdata;
  } cmbi_peri_cmd_t;

endpackage

// ==== logic/cmbi_rd_capture.sv ====
/*
  Read-return capture stage: registers returned read data and raises a
  one-cycle valid in the cycle the data is presented to the core.
  Assumes take stands in the cycle the read command stands, one cycle before
  the data input holds the answer.
*/
`timescale 1ns/100ps
`default_nettype none
module cmbi_rd_capture #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Returned data
  input wire logic take,
  input wire logic [W-1:0] data,
  // Toward the core
  output logic valid,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic pend;
    logic valid;
    logic [W-1:0] q;
  } cmbi_cap_state_t;

  cmbi_cap_state_t state;
  cmbi_cap_state_t next_state;

  if (W < 1) begin : gWidthCheck
    $error("cmbi_rd_capture: width must be at least 1");
  end

  always_comb begin
    next_state = state;
    // Target answers a cycle after its command, so the capture waits one cycle
    next_state.pend = take;
    next_state.valid = state.pend;
    // Data holds until the next answer so the core may sample late
    if (state.pend) begin
      next_state.q = data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign valid = state.valid;
  assign q = state.q;

endmodule
`default_nettype wire

// ==== logic/cmbi_core_bus.sv ====
/*
  Core-side memory and peripheral bus interface: routes program fetches and
  writes, primary byte/word/long data accesses, dual-read secondary accesses
  and peripheral register accesses from the core to their targets, and returns
  read data to the core with a fixed latency.
  Assumes memories and peripherals sample a command on the clock edge after it
  is presented and drive read data during the following cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module cmbi_core_bus #(
  parameter int PERI_WIN_BITS = cmbi_pkg::PERI_WIN_BITS_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Core request and response
  input wire cmbi_pkg::cmbi_core_req_t coreReq,
  output cmbi_pkg::cmbi_core_rsp_t coreRsp,
  // Program memory
  output cmbi_pkg::cmbi_pmem_cmd_t pgmCmd,
  input wire logic [cmbi_pkg::PGM_DW-1:0] pgmRdata,
  // Primary data memory
  output cmbi_pkg::cmbi_xmem_cmd_t dataCmd,
  input wire logic [cmbi_pkg::DATA_DW-1:0] dataRdata,
  // Secondary data memory read port
  output cmbi_pkg::cmbi_smem_cmd_t secCmd,
  input wire logic [cmbi_pkg::SEC_DW-1:0] secondaryReadBus,
  // Peripheral register bus
  output cmbi_pkg::cmbi_peri_cmd_t periCmd,
  input wire logic [cmbi_pkg::PERI_DW-1:0] peripheralRegisterBus
);
  import cmbi_pkg::*;

  typedef struct packed {
    cmbi_pmem_cmd_t pgm;
    cmbi_xmem_cmd_t data;
    cmbi_smem_cmd_t sec;
    cmbi_peri_cmd_t peri;
    logic periPend;
  } cmbi_state_t;

  cmbi_state_t state;
  cmbi_state_t next_state;

  logic [DATA_AW-1:0] effAddr;
  logic isPeri;
  logic dataRd;
  logic dataWr;
  logic [DATA_DW-1:0] primReturn;
  logic pgmValid;
  logic primValid;
  logic secValid;
  logic [PGM_DW-1:0] pgmQ;
  logic [DATA_DW-1:0] primQ;
  logic [SEC_DW-1:0] secQ;

  if (PERI_WIN_BITS < 1 || PERI_WIN_BITS > PERI_AW || PERI_WIN_BITS >= DATA_AW) begin : gWinCheck
    $error("cmbi_core_bus: peripheral window width out of range");
  end

  always_comb begin
    // Byte operands live in the lower half only
    effAddr = coreReq.primaryDataAddress;
    if (coreReq.dataSize == CMBI_SZ_BYTE) begin
      effAddr[ADDR_MSB] = 1'b0;
    end
    // Same address decodes data memory and register window
    isPeri = (effAddr[DATA_AW-1:PERI_WIN_BITS] == PERI_BASE[DATA_AW-1:PERI_WIN_BITS]);
    dataRd = coreReq.dataReq && !coreReq.dataWrite;
    dataWr = coreReq.dataReq && coreReq.dataWrite;
  end

  always_comb begin
    next_state = state;

    // Program side: address and write data pass with one cycle of staging
    next_state.pgm.rd = coreReq.pgmReq && !coreReq.pgmWrite;
    next_state.pgm.wr = coreReq.pgmReq && coreReq.pgmWrite;
    if (coreReq.pgmReq) begin
      next_state.pgm.addr = coreReq.pgmAddr;
      // Upper half of the write bus never reaches program memory
      next_state.pgm.wdata = coreReq.writeData[PGM_DW-1:0];
    end

    // Primary data memory
    next_state.data.rd = dataRd && !isPeri;
    next_state.data.wr = dataWr && !isPeri;
    if (coreReq.dataReq && !isPeri) begin
      next_state.data.addr = effAddr;
      next_state.data.size = coreReq.dataSize;
      next_state.data.wdata = coreReq.writeData;
    end

    // Register bus staged exactly like data memory, so no extra wait
    next_state.peri.rd = dataRd && isPeri;
    // Marks the cycle in which the register bus, not data memory, answers
    next_state.periPend = state.peri.rd;
    next_state.peri.wr = dataWr && isPeri;
    if (coreReq.dataReq && isPeri) begin
      next_state.peri.addr = PERI_AW'(effAddr[PERI_WIN_BITS-1:0]);
      // Register writes come off the primary write bus
      next_state.peri.wdata = coreReq.writeData[PERI_DW-1:0];
    end

    // Secondary port only joins a primary read; a stray dual flag is dropped
    next_state.sec.rd = coreReq.dualReq && dataRd;
    if (coreReq.dualReq && dataRd) begin
      next_state.sec.addr = coreReq.secondaryDataAddress;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pgmCmd = state.pgm;
  assign dataCmd = state.data;
  assign secCmd = state.sec;
  assign periCmd = state.peri;

  // Register reads land on the primary read bus, zero-extended
  assign primReturn = state.periPend ? {{(DATA_DW-PERI_DW){1'b0}}, peripheralRegisterBus} : dataRdata;

  cmbi_rd_capture #(.W(PGM_DW)) uPgmCap (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .take(state.pgm.rd),
    .data(pgmRdata),
    .valid(pgmValid),
    .q(pgmQ)
  );

  // Primary and secondary share one latency, so a dual read returns together
  cmbi_rd_capture #(.W(DATA_DW)) uPrimCap (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .take(state.data.rd || state.peri.rd),
    .data(primReturn),
    .valid(primValid),
    .q(primQ)
  );

  cmbi_rd_capture #(.W(SEC_DW)) uSecCap (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .take(state.sec.rd),
    .data(secondaryReadBus),
    .valid(secValid),
    .q(secQ)
  );

  always_comb begin
    coreRsp.pgmValid = pgmValid;
    coreRsp.pgmData = pgmQ;
    coreRsp.primValid = primValid;
    coreRsp.primData = primQ;
    coreRsp.secValid = secValid;
    coreRsp.secondaryReadBus = secQ;
  end

endmodule
`default_nettype wire

// ==== sim/cmbi_mem_model.sv ====
/* Memories and register bus behind the core bus block.
   Assumes each read command is answered during the next cycle. */
`timescale 1ns/100ps
`default_nettype none
module cmbi_mem_model (
  // Clock
  input wire logic clk_sys,
  // Commands
  input wire cmbi_pkg::cmbi_pmem_cmd_t pgmCmd,
  input wire cmbi_pkg::cmbi_xmem_cmd_t dataCmd,
  input wire cmbi_pkg::cmbi_smem_cmd_t secCmd,
  input wire cmbi_pkg::cmbi_peri_cmd_t periCmd,
  // Read data
  output logic [15:0] pgmRdata,
  output logic [31:0] dataRdata,
  output logic [15:0] secondaryReadBus,
  output logic [15:0] peripheralRegisterBus
);
  import cmbi_pkg::*;
  // Idle buses flip so a stale word never passes for an answer
  always_ff @(posedge clk_sys) begin
    pgmRdata <= pgmCmd.rd ? pgmCmd.addr[15:0] ^ 16'h5a5a : ~pgmRdata;
    dataRdata <= dataCmd.rd ? {8'h00, dataCmd.addr} : ~dataRdata;
    secondaryReadBus <= secCmd.rd ? secCmd.addr[15:0] ^ 16'ha5a5 : ~secondaryReadBus;
    peripheralRegisterBus <= periCmd.rd ? periCmd.addr ^ 16'h3c3c : ~peripheralRegisterBus;
  end
endmodule
`default_nettype wire

// ==== sim/cmbi_bus_checker.sv ====
/* Timing checks for the core bus block.
   Assumes it is bound to the block's top module. */
`timescale 1ns/100ps
`default_nettype none
module cmbi_bus_checker #(
  parameter int PERI_WIN_BITS = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Core side
  input wire cmbi_pkg::cmbi_core_req_t coreReq,
  input wire cmbi_pkg::cmbi_core_rsp_t coreRsp,
  // Targets
  input wire cmbi_pkg::cmbi_pmem_cmd_t pgmCmd,
  input wire logic [15:0] pgmRdata,
  input wire cmbi_pkg::cmbi_xmem_cmd_t dataCmd,
  input wire logic [31:0] dataRdata,
  input wire cmbi_pkg::cmbi_smem_cmd_t secCmd,
  input wire logic [15:0] secondaryReadBus,
  input wire cmbi_pkg::cmbi_peri_cmd_t periCmd,
  input wire logic [15:0] peripheralRegisterBus
);
  import cmbi_pkg::*;
  wire logic [23:0] ea = {coreReq.dataSize != CMBI_SZ_BYTE && coreReq.primaryDataAddress[23],
    coreReq.primaryDataAddress[22:0]};
  wire logic win = ea[23:PERI_WIN_BITS] == PERI_BASE[23:PERI_WIN_BITS];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_dual;
    dataCmd.rd && secCmd.rd ##2 coreRsp.primValid && coreRsp.secValid
      && coreRsp.secondaryReadBus == $past(secondaryReadBus);
  endsequence
  a_pgm_read: assert property (coreReq.pgmReq && !coreReq.pgmWrite |=> pgmCmd.rd ##2 coreRsp.pgmValid
    && coreRsp.pgmData == $past(pgmRdata)) else $error("program read wrong");
  a_pgm_write: assert property (coreReq.pgmReq && coreReq.pgmWrite |=> pgmCmd.wr
    && pgmCmd.wdata == $past(coreReq.writeData[15:0])) else $error("program write wrong");
  a_data_route: assert property (coreReq.dataReq && !win |=> dataCmd.addr == $past(ea)
    && dataCmd.wr == $past(coreReq.dataWrite) && dataCmd.rd != dataCmd.wr) else $error("data route wrong");
  a_data_answer: assert property (dataCmd.rd |=> ##1 coreRsp.primValid
    && coreRsp.primData == $past(dataRdata)) else $error("data answer wrong");
  a_peri_write: assert property (coreReq.dataReq && win && coreReq.dataWrite |=> periCmd.wr && !dataCmd.wr
    && periCmd.wdata == $past(coreReq.writeData[15:0])) else $error("register write wrong");
  a_peri_answer: assert property (periCmd.rd |=> ##1 coreRsp.primValid
    && coreRsp.primData == {16'h0000, $past(peripheralRegisterBus)}) else $error("register read wrong");
  a_byte_msb: assert property ((dataCmd.rd || dataCmd.wr) && dataCmd.size == CMBI_SZ_BYTE
    |-> !dataCmd.addr[23]) else $error("byte address high");
  a_dual_pair: assert property (coreReq.dataReq && !coreReq.dataWrite && coreReq.dualReq && !win
    |=> s_dual) else $error("dual read split");
endmodule
`default_nettype wire

// ==== sim/cmbi_core_bus_tb.sv ====
/* Self-checking bench for the core bus block.
   Assumes the memory model answers one cycle after a read command. */
`timescale 1ns/100ps
`default_nettype none
module cmbi_core_bus_tb;
  import cmbi_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  cmbi_core_req_t coreReq = '0;
  cmbi_core_req_t r;
  cmbi_core_rsp_t coreRsp;
  cmbi_pmem_cmd_t pgmCmd;
  cmbi_xmem_cmd_t dataCmd;
  cmbi_smem_cmd_t secCmd;
  cmbi_peri_cmd_t periCmd;
  logic [15:0] pgmRdata;
  logic [31:0] dataRdata;
  logic [15:0] secondaryReadBus;
  logic [15:0] peripheralRegisterBus;
  int error_cnt = 0;
  int compares = 0;
  cmbi_core_bus dut_u (.clk_sys, .resetn, .coreReq, .coreRsp, .pgmCmd, .pgmRdata, .dataCmd, .dataRdata,
    .secCmd, .secondaryReadBus, .periCmd, .peripheralRegisterBus);
  cmbi_mem_model mem_u (.clk_sys, .pgmCmd, .dataCmd, .secCmd, .periCmd, .pgmRdata, .dataRdata,
    .secondaryReadBus, .peripheralRegisterBus);
  initial forever #2 clk_sys = ~clk_sys;
  // Wide enough for the widest packed compare below
  task chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request for one cycle; returns while its command is visible
  task go;
    @(posedge clk_sys) coreReq <= r;
    @(posedge clk_sys) coreReq <= '0;
    #1;
  endtask
  task ans;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task t_pgm;
    r = '0; r.pgmReq = 1'b1; r.pgmAddr = 21'h1abcde;
    go; chk(pgmCmd.rd, 1);
    ans; chk({coreRsp.pgmValid, coreRsp.pgmData}, 17'h1e684);
    r.pgmWrite = 1'b1; r.writeData = 32'h1234abcd;
    go; chk({pgmCmd.wr, pgmCmd.wdata}, 17'h1abcd);
    $display("program test done");
  endtask
  task t_data;
    r = '0; r.dataReq = 1'b1; r.primaryDataAddress = 24'h812345;
    go; chk({dataCmd.rd, dataCmd.addr}, 25'h1012345);
    ans; chk(coreRsp.primData, 32'h00012345);
    r.dataWrite = 1'b1; r.dataSize = CMBI_SZ_LONG; r.writeData = 32'hcafef00d;
    go; chk(dataCmd.wdata, 32'hcafef00d);
    chk({dataCmd.wr, dataCmd.size, dataCmd.addr}, 27'h6812345);
    $display("data test done");
  endtask
  task t_peri;
    r = '0; r.dataReq = 1'b1; r.dataWrite = 1'b1; r.dataSize = CMBI_SZ_LONG;
    r.primaryDataAddress = 24'h00f004; r.writeData = 32'h5555beef;
    go; chk({dataCmd.wr, periCmd.wr, periCmd.addr, periCmd.wdata}, 34'h10004beef);
    r.dataWrite = 1'b0; r.dataSize = CMBI_SZ_BYTE; r.primaryDataAddress = 24'h80f010;
    go; chk({periCmd.rd, periCmd.addr}, 17'h10010);
    ans; chk({coreRsp.primValid, coreRsp.primData}, 33'h100003c2c);
    $display("register test done");
  endtask
  task t_dual;
    r = '0; r.dataReq = 1'b1; r.dualReq = 1'b1; r.dataSize = CMBI_SZ_WORD;
    r.primaryDataAddress = 24'h000100; r.secondaryDataAddress = 24'h000200;
    go; chk({dataCmd.rd, secCmd.rd}, 2'b11);
    ans; chk({coreRsp.primValid, coreRsp.secValid, coreRsp.secondaryReadBus}, 18'h3a7a5);
    r.dataWrite = 1'b1;
    go; chk(secCmd.rd, 0);
    $display("dual test done");
  endtask
  task report_and_stop;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_pgm;
    t_data;
    t_peri;
    t_dual;
    report_and_stop;
  end
  // About forty cycles of tests; twenty-five times that means a hang
  initial begin
    #4000;
    error_cnt++;
    report_and_stop;
  end
endmodule
bind cmbi_core_bus cmbi_bus_checker #(.PERI_WIN_BITS(PERI_WIN_BITS)) chk_u (.clk_sys, .resetn, .coreReq,
  .coreRsp, .pgmCmd, .pgmRdata, .dataCmd, .dataRdata, .secCmd, .secondaryReadBus, .periCmd, .peripheralRegisterBus);
`default_nettype wire
